//--- hw/can_bit_checker.sv
// Purpose: Bit, stuff and CRC error detection on the bit stream
// Assumes: One bit_valid pulse per bus bit, field and stuff marks from the engine
// Notes: Each error comes out as a one-cycle pulse the cycle after its bit
`timescale 1ns/10ps
`default_nettype none
`include "can_status_regs.svh"
module can_bit_checker import can_status_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  can_bit_if.monitor bus
);
  logic prev_level; // Level of the previous bit
  logic [2:0] run_len; // Equal bits seen in a row
  logic [14:0] crc_calc; // Running CRC over the de-stuffed frame
  logic [14:0] crc_rcvd; // CRC field as received
  logic [3:0] crc_cnt; // CRC field bits taken so far
  logic bit_err; // Registered error pulses
  logic stuff_err;
  logic crc_err;
  logic in_stuffed; // Field covered by bit stuffing
  logic crc_region; // Field covered by the CRC after start of frame
  logic mismatch; // Bus level differs from driven level
  logic exempt; // Mismatch that is allowed

  // One CRC shift step
  function automatic logic [14:0] crc_step(input logic [14:0] c, input logic b);
    logic fb;
    fb = b ^ c[14];
    crc_step = {c[13:0], 1'b0} ^ (fb ? `CRC_POLY : 15'h0000);
  endfunction

  assign in_stuffed = (bus.field == fld_arb) || (bus.field == fld_ctrl_data) ||
    (bus.field == fld_crc);
  assign crc_region = (bus.field == fld_arb) || (bus.field == fld_ctrl_data);
  assign mismatch = bus.rx_level != bus.tx_level;
  // Lost arbitration and a dominant ack during an error frame (see RULE_08)
  assign exempt = ((bus.field == fld_arb) && bus.tx_level && !bus.rx_level) ||
    ((bus.field == fld_ack) && bus.error_frame && !bus.rx_level);
  assign bus.bit_err = bit_err;
  assign bus.stuff_err = stuff_err;
  assign bus.crc_err = crc_err;

  // Bit monitor, only while sending
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_err <= 1'b0;
    end else begin
      bit_err <= bus.bit_valid && bus.transmitting && mismatch && !exempt; // see RULE_07
    end
  end

  // Run length of equal bits
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_level <= 1'b1;
      run_len <= 3'h0;
      stuff_err <= 1'b0;
    end else begin
      stuff_err <= 1'b0;
      if (bus.bit_valid && bus.field == fld_sof) begin
        prev_level <= bus.rx_level;
        run_len <= 3'h1;
      end else if (bus.bit_valid && in_stuffed) begin
        prev_level <= bus.rx_level;
        if (bus.rx_level != prev_level) begin
          run_len <= 3'h1;
        end else if (run_len == `STUFF_RUN_MAX) begin
          stuff_err <= 1'b1; // Sixth equal bit, see RULE_09
        end else begin
          run_len <= run_len + 3'h1;
        end
      end
    end
  end

  // CRC from start of frame through data, then compare with the field
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_calc <= 15'h0000;
      crc_rcvd <= 15'h0000;
      crc_cnt <= 4'h0;
      crc_err <= 1'b0;
    end else begin
      crc_err <= 1'b0;
      if (bus.bit_valid && !bus.stuff_bit) begin
        if (bus.field == fld_sof) begin
          crc_calc <= crc_step(15'h0000, bus.rx_level); // see RULE_10
          crc_cnt <= 4'h0;
        end else if (crc_region) begin
          crc_calc <= crc_step(crc_calc, bus.rx_level); // see RULE_10
        end else if (bus.field == fld_crc && crc_cnt != `CRC_BITS) begin
          crc_rcvd <= {crc_rcvd[13:0], bus.rx_level};
          crc_cnt <= crc_cnt + 4'h1;
          if (crc_cnt == `CRC_BITS - 4'h1) begin
            crc_err <= {crc_rcvd[13:0], bus.rx_level} != crc_calc; // see RULE_10
          end
        end
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  bit_error_flag_a: assert property (bus.bit_valid && bus.transmitting && mismatch && !exempt
    |=> bit_err) else $error("bit error not flagged"); // see RULE_07
  bit_exempt_a: assert property (bus.bit_valid && exempt |=> !bit_err)
    else $error("exempt mismatch flagged"); // see RULE_08
  sequence sixth_equal_s;
    bus.bit_valid && in_stuffed && (bus.rx_level == prev_level) && run_len == `STUFF_RUN_MAX;
  endsequence
  stuff_run_a: assert property (sixth_equal_s |=> stuff_err ##1 !stuff_err)
    else $error("stuff error not a single pulse"); // see RULE_09
endmodule // can_bit_checker
`default_nettype wire

//--- hw/can_bit_if.sv
// Purpose: Bit stream and error pulses between the flag logic and the bit checker
// Assumes: One clock; every signal is sampled on hclk
// Notes: Engine side drives the stream, checker side answers with pulses
`timescale 1ns/10ps
`default_nettype none
interface can_bit_if;
  import can_status_pkg::*;
  logic bit_valid; // One pulse per bus bit at the sample point
  logic rx_level; // Synchronised bus level
  logic tx_level; // Level this node drives
  logic transmitting; // This node is the sender
  logic error_frame; // This node is sending an error frame
  logic stuff_bit; // The current bit is a stuff bit
  can_field_e field; // Field that holds the current bit
  logic bit_err; // Bit error pulse
  logic stuff_err; // Stuff error pulse
  logic crc_err; // CRC error pulse
  modport engine (output bit_valid, rx_level, tx_level, transmitting, error_frame, stuff_bit,
    field, input bit_err, stuff_err, crc_err);
  modport monitor (input bit_valid, rx_level, tx_level, transmitting, error_frame, stuff_bit,
    field, output bit_err, stuff_err, crc_err);
endinterface
`default_nettype wire

//--- hw/can_msg_object_status_flags.sv
// Purpose: Per message object status flags of a CAN controller, on AHB-Lite
// Assumes: The protocol engine runs on hclk and marks bits, fields and objects
// Notes: Objects 0 to 14; flag storage is not reset
//
// How it works
// RULE_01 - Object registers keep no reset value
// RULE_02 - Length mismatch sets bit 7, overwrites length
// RULE_03 - Transmit complete sets bit 6 at frame end
// RULE_04 - Lowest enabled transmit object sent first
// RULE_05 - Receive complete bit 5 after sixth end bit
// RULE_06 - Matching receive object with lowest index stored
// RULE_07 - Bit error bit 4 when sending mismatches
// RULE_08 - No bit error for arbitration or ack; code exempts only lost arbitration and a dominant ack in an error frame
// RULE_09 - Stuff error bit 3 on six equal bits
// RULE_10 - CRC mismatch over de-stuffed frame sets bit 2
// RULE_11 - Software clears flags by whole-register rewrite
// RULE_12 - Completion and error flags can raise interrupts
// RULE_13 - Flags stay set until software clears them
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "can_status_regs.svh"
module can_msg_object_status_flags import can_status_pkg::*; #(
  parameter int NUM_OBJ = 15
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  input wire logic can_rx,
  input wire logic bit_valid,
  input wire logic bit_is_stuff,
  input wire can_field_e field,
  input wire logic [2:0] eof_index,
  input wire logic tx_level,
  input wire logic transmitting,
  input wire logic sending_error_frame,
  input wire logic [NUM_OBJ-1:0] tx_enabled,
  input wire logic [NUM_OBJ-1:0] rx_matched,
  input wire logic [3:0] rx_dlc,
  input wire logic rx_dlc_valid
);
  can_bit_if bit_bus(); // Stream to the bit checker
  logic rx_meta; // First synchroniser stage of the bus pin
  logic rx_sync; // Second synchroniser stage
  frame_state_e state; // Role in the current frame
  frame_state_e next_state;
  obj_idx_t active_idx; // Object that owns the current frame
  logic active_valid; // An object owns the current frame
  logic frame_err; // An error was seen in this frame
  obj_idx_t obj_sel; // Object that software looks at
  logic [`INT_WIDTH-1:0] int_status; // Sticky interrupt causes
  logic [`INT_WIDTH-1:0] int_enable; // Interrupt enables
  logic wr_pend; // Write data phase pending
  logic [7:0] wr_ofs; // Offset of the pending write
  logic addr_phase; // Valid AHB address phase
  logic sof_bit; // Start of frame bit
  logic eof_bit; // End of frame bit
  logic tx_done; // Transmission finished well
  logic rx_done; // Reception finished well
  logic rx_pick; // Receive object chosen
  logic dlc_mismatch; // Received length differs from expected
  logic any_err; // Checker reported an error
  logic err_take; // Error can be charged to an object
  obj_idx_t set_addr; // Object whose flags are set this cycle
  logic [7:0] set_mask; // Flags set this cycle
  logic sw_we; // Software writes object storage
  logic [1:0] sw_be; // Which part of the object word
  logic clear_hit; // Write to the interrupt clear register
  logic [11:0] sw_rdata; // Selected object word
  logic [11:0] hw_rdata; // Expected length lookup
  obj_idx_t hw_raddr; // Object looked up for the length check

  // Index of the lowest set request bit
  function automatic obj_idx_t lowest_index(input logic [NUM_OBJ-1:0] req);
    obj_idx_t idx;
    idx = 4'h0;
    for (int i = NUM_OBJ - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = obj_idx_t'(i);
      end
    end
    return idx;
  endfunction

  // Bus pin synchroniser; only the second stage is read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= can_rx;
      rx_sync <= rx_meta;
    end
  end

  // Hand the bit stream to the checker
  assign bit_bus.bit_valid = bit_valid;
  assign bit_bus.rx_level = rx_sync;
  assign bit_bus.tx_level = tx_level;
  assign bit_bus.transmitting = transmitting;
  assign bit_bus.error_frame = sending_error_frame;
  assign bit_bus.stuff_bit = bit_is_stuff;
  assign bit_bus.field = field;

  can_bit_checker u_checker (
    .hclk(hclk),
    .hresetn(hresetn),
    .bus(bit_bus.monitor)
  );

  // Frame events
  assign sof_bit = bit_valid && field == fld_sof;
  assign eof_bit = bit_valid && field == fld_eof;
  assign any_err = bit_bus.bit_err || bit_bus.stuff_err || bit_bus.crc_err;
  assign tx_done = state == st_tx && eof_bit && eof_index == `EOF_TX_DONE && !frame_err
    && transmitting; // see RULE_03
  assign rx_done = state == st_rx && active_valid && eof_bit && eof_index == `EOF_RX_DONE
    && !frame_err; // see RULE_05
  assign rx_pick = state == st_rx && rx_dlc_valid && (|rx_matched);
  assign hw_raddr = lowest_index(rx_matched);
  // Expected length read one cycle earlier from the same object
  assign dlc_mismatch = rx_pick && rx_dlc != hw_rdata[11:8]; // see RULE_02
  assign set_addr = rx_pick ? lowest_index(rx_matched) : active_idx; // see RULE_06
  assign err_take = active_valid || rx_pick;

  // Flags raised this cycle
  always_comb begin
    set_mask = 8'h00;
    set_mask[`ST_LEN_WARN] = dlc_mismatch; // see RULE_02
    set_mask[`ST_TX_DONE] = tx_done; // see RULE_03
    set_mask[`ST_RX_DONE] = rx_done; // see RULE_05
    set_mask[`ST_BIT_ERR] = err_take && bit_bus.bit_err; // see RULE_07
    set_mask[`ST_STUFF_ERR] = err_take && bit_bus.stuff_err; // see RULE_09
    set_mask[`ST_CRC_ERR] = err_take && bit_bus.crc_err; // see RULE_10
  end

  // Next frame role
  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (sof_bit) begin
          next_state = (transmitting && (|tx_enabled)) ? st_tx : st_rx;
        end
      end
      st_tx: begin
        if (tx_done || (eof_bit && eof_index == `EOF_TX_DONE)) begin
          next_state = st_idle;
        end else if (!transmitting) begin
          next_state = st_rx; // Lost arbitration, now a receiver
        end
      end
      st_rx: begin
        if (eof_bit && eof_index == `EOF_TX_DONE) begin
          next_state = st_idle;
        end
      end
      default: next_state = st_idle;
    endcase
  end

  // Frame role and owning object
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= st_idle;
      active_idx <= 4'h0;
      active_valid <= 1'b0;
    end else begin
      state <= next_state;
      if (state == st_idle && sof_bit) begin
        active_idx <= lowest_index(tx_enabled); // see RULE_04
        active_valid <= transmitting && (|tx_enabled);
      end else if (rx_pick) begin
        active_idx <= lowest_index(rx_matched); // see RULE_06
        active_valid <= 1'b1;
      end else if (state == st_tx && !transmitting) begin
        active_valid <= 1'b0;
      end else if (next_state == st_idle) begin
        active_valid <= 1'b0;
      end
    end
  end

  // Error seen in the current frame blocks its completion flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame_err <= 1'b0;
    end else if (sof_bit) begin
      frame_err <= 1'b0;
    end else if (any_err) begin
      frame_err <= 1'b1;
    end
  end

  // AHB-Lite address phase capture for writes
  assign addr_phase = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_ofs <= 8'h00;
    end else begin
      wr_pend <= addr_phase && hwrite;
      if (addr_phase) begin
        wr_ofs <= haddr[7:0];
      end
    end
  end

  // Object storage writes: whole status byte, as software rewrites it (see RULE_11)
  assign sw_we = wr_pend && (wr_ofs == `OFS_STATUS || wr_ofs == `OFS_CTRL_LEN);
  assign sw_be = {wr_ofs == `OFS_CTRL_LEN, wr_ofs == `OFS_STATUS};
  assign clear_hit = wr_pend && wr_ofs == `OFS_INT_CLEAR;

  object_status_mem #(
    .AW(4)
  ) u_mem (
    .hclk(hclk),
    .sw_addr(obj_sel),
    .sw_we(sw_we),
    .sw_be(sw_be),
    .sw_wdata({hwdata[3:0], hwdata[7:0]}),
    .hw_addr(set_addr),
    .hw_set(set_mask),
    .hw_dlc_we(dlc_mismatch),
    .hw_dlc(rx_dlc),
    .hw_raddr(hw_raddr),
    .sw_rdata(sw_rdata),
    .hw_rdata(hw_rdata)
  );

  // Software control registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      obj_sel <= `OBJ_SEL_RESET;
      int_enable <= `INT_ENABLE_RESET;
    end else if (wr_pend) begin
      case (wr_ofs)
        `OFS_OBJ_SEL: obj_sel <= hwdata[3:0];
        `OFS_INT_ENABLE: int_enable <= hwdata[`INT_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // Sticky interrupt causes; a new event wins over a clear (see RULE_12)
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_status <= 5'h00;
    end else begin
      int_status <= (int_status & ~(clear_hit ? hwdata[`INT_WIDTH-1:0] : 5'h00))
        | set_mask[`ST_TX_DONE:`ST_CRC_ERR]; // see RULE_13
    end
  end

  // Level interrupt from enabled causes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_enable); // see RULE_12
    end
  end

  // Zero wait state, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Read data, loaded at the address phase; unmapped reads as zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      case (haddr[7:0])
        `OFS_OBJ_SEL: hrdata <= {28'h0000000, obj_sel};
        `OFS_STATUS: hrdata <= {24'h000000, sw_rdata[7:0]};
        `OFS_CTRL_LEN: hrdata <= {28'h0000000, sw_rdata[11:8]};
        `OFS_INT_STATUS: hrdata <= {27'h0000000, int_status};
        `OFS_INT_ENABLE: hrdata <= {27'h0000000, int_enable};
        `OFS_ACTIVE: hrdata <= {25'h0000000, state, active_valid, active_idx};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence tx_last_bit_s;
    state == st_tx && eof_bit && eof_index == `EOF_TX_DONE && !frame_err && transmitting;
  endsequence
  sequence rx_sixth_bit_s;
    state == st_rx && active_valid && eof_bit && eof_index == `EOF_RX_DONE && !frame_err;
  endsequence
  tx_done_flag_a: assert property (tx_last_bit_s |=> int_status[`INT_TX] ##1 state == st_idle)
    else $error("transmit complete not raised"); // see RULE_03
  rx_done_flag_a: assert property (rx_sixth_bit_s |=> int_status[`INT_RX])
    else $error("receive complete not raised"); // see RULE_05
  tx_lowest_pick_a: assert property (state == st_idle && sof_bit && transmitting
    && (|tx_enabled) |=> state == st_tx && active_idx == lowest_index($past(tx_enabled)))
    else $error("transmit object not lowest"); // see RULE_04
  rx_lowest_pick_a: assert property (rx_pick |=> active_valid
    && active_idx == lowest_index($past(rx_matched)))
    else $error("receive object not lowest"); // see RULE_06
  dlc_overwrite_a: assert property (dlc_mismatch ##1 (hw_raddr == $past(hw_raddr)) |=>
    hw_rdata[11:8] == $past(rx_dlc, 2) && hw_rdata[7])
    else $error("length not overwritten"); // see RULE_02
  crc_flag_a: assert property (bit_bus.crc_err && active_valid |=> int_status[`INT_CRC])
    else $error("crc error not recorded"); // see RULE_10
  irq_level_a: assert property ((|(int_status & int_enable)) [*2] |-> irq)
    else $error("interrupt not raised"); // see RULE_12
  flag_sticky_a: assert property (!clear_hit |=>
    (int_status & $past(int_status)) == $past(int_status))
    else $error("flag dropped without clear"); // see RULE_13
endmodule // can_msg_object_status_flags
`default_nettype wire

//--- hw/can_status_pkg.sv
// Purpose: Types shared by the status flag block
// Assumes: Nothing beyond the register header
// Notes: Enumerations and the object index type; numbers live in the register header
package can_status_pkg;
  // Frame field currently on the bus, told by the protocol engine
  typedef enum logic [2:0] {fld_idle, fld_sof, fld_arb, fld_ctrl_data, fld_crc, fld_ack,
    fld_eof} can_field_e;
  // Role of this node in the current frame
  typedef enum logic [1:0] {st_idle, st_tx, st_rx} frame_state_e;
  // Message object index
  typedef logic [3:0] obj_idx_t;
endpackage

//--- hw/can_status_regs.svh
// Purpose: Register offsets, status bit positions and timing counts
// Assumes: AHB-Lite byte addresses, one aligned 32-bit word per register
// Notes: Included by bare name by every design file that needs it
`ifndef CAN_STATUS_REGS_SVH
`define CAN_STATUS_REGS_SVH
// Register byte offsets
`define OFS_OBJ_SEL 8'h00
`define OFS_STATUS 8'h04
`define OFS_CTRL_LEN 8'h08
`define OFS_INT_STATUS 8'h0c
`define OFS_INT_CLEAR 8'h10
`define OFS_INT_ENABLE 8'h14
`define OFS_ACTIVE 8'h18
// Status bit positions
`define ST_LEN_WARN 7
`define ST_TX_DONE 6
`define ST_RX_DONE 5
`define ST_BIT_ERR 4
`define ST_STUFF_ERR 3
`define ST_CRC_ERR 2
// Interrupt bits mirror status bits 6..2
`define INT_WIDTH 5
`define INT_TX 4
`define INT_RX 3
`define INT_CRC 0
// Reset values of the software registers
`define OBJ_SEL_RESET 4'h0
`define INT_ENABLE_RESET 5'h00
// Frame timing, as bit indices within end of frame
`define EOF_TX_DONE 3'h6
`define EOF_RX_DONE 3'h5
// Longest legal run of equal bits
`define STUFF_RUN_MAX 3'h5
// Frame check sequence
`define CRC_POLY 15'h4599
`define CRC_BITS 4'hf
`endif

//--- hw/object_status_mem.sv
// Purpose: Status byte and length code of every message object
// Assumes: One software write port, one hardware set port, two registered reads
// Notes: No reset on the array; contents are unknown until software writes them
`timescale 1ns/10ps
`default_nettype none
module object_status_mem #(
  parameter int AW = 4
) (
  input wire logic hclk,
  input wire logic [AW-1:0] sw_addr,
  input wire logic sw_we,
  input wire logic [1:0] sw_be,
  input wire logic [11:0] sw_wdata,
  input wire logic [AW-1:0] hw_addr,
  input wire logic [7:0] hw_set,
  input wire logic hw_dlc_we,
  input wire logic [3:0] hw_dlc,
  input wire logic [AW-1:0] hw_raddr,
  output logic [11:0] sw_rdata,
  output logic [11:0] hw_rdata
);
  // Word layout: length code in 11..8, status flags in 7..0
  logic [11:0] mem [0:(1<<AW)-1];

  // Writes; no reset branch on purpose (see RULE_01)
  always_ff @(posedge hclk) begin
    for (int i = 0; i < (1 << AW); i++) begin
      if (sw_we && sw_addr == AW'(i) && sw_be[0]) begin
        // Software value, but a flag set in the same cycle wins (see RULE_13)
        mem[i][7:0] <= sw_wdata[7:0] | ((hw_addr == AW'(i)) ? hw_set : 8'h00);
      end else if (hw_addr == AW'(i)) begin
        // Flags only ever get set by hardware (see RULE_13)
        mem[i][7:0] <= mem[i][7:0] | hw_set;
      end
      if (hw_dlc_we && hw_addr == AW'(i)) begin
        // Received length overwrites the expected one (see RULE_02)
        mem[i][11:8] <= hw_dlc;
      end else if (sw_we && sw_addr == AW'(i) && sw_be[1]) begin
        mem[i][11:8] <= sw_wdata[11:8];
      end
    end
  end

  // Registered read ports
  always_ff @(posedge hclk) begin
    sw_rdata <= mem[sw_addr];
    hw_rdata <= mem[hw_raddr];
  end
endmodule // object_status_mem
`default_nettype wire

//--- sim/can_far_node.sv
// Purpose: Other CAN node sharing the bus with this controller
// Assumes: Wired-AND bus, dominant is 0
// Notes: Sends recessive whenever it has nothing to say
`timescale 1ns/10ps
`default_nettype none
module can_far_node (
  input wire logic node_bit,
  input wire logic our_bit,
  output logic can_rx
);
  // Dominant level from either node wins the wire
  assign can_rx = node_bit & our_bit;
endmodule // can_far_node
`default_nettype wire

//--- sim/can_msg_object_status_flags_tb.sv
// Purpose: Random frames against the status flag block
// Assumes: Bench plays the protocol engine and the bus master
// Notes: Frame is sof, 4 arb, 8 data, crc, ack and eof bits
`timescale 1ns/10ps
`default_nettype none
`include "can_status_regs.svh"
module can_msg_object_status_flags_tb;
  import can_status_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, can_rx;
  logic bit_valid, stf, txl, tx_on, nb, brk, nostuff, last, rx_dlc_valid, ef;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] ei;
  logic [14:0] ten, rm, crc;
  logic [3:0] dlc, rx_dlc;
  logic [7:0] tbl [6] = '{8'h40, 8'h20, 8'h04, 8'h10, 8'h00, 8'h08}; // Flags per case
  can_field_e fld;
  int n_errors, cmp_count, seed, run, k;
  assign hready = hreadyout;
  can_msg_object_status_flags u_can_msg_object_status_flags (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .irq(irq), .can_rx(can_rx), .bit_valid(bit_valid), .bit_is_stuff(stf), .field(fld),
    .eof_index(ei), .tx_level(txl), .transmitting(tx_on), .sending_error_frame(ef),
    .tx_enabled(ten), .rx_matched(rm), .rx_dlc(rx_dlc), .rx_dlc_valid(rx_dlc_valid));
  can_far_node u_can_far_node (.node_bit(nb), .our_bit(txl), .can_rx(can_rx));
  initial begin
    hclk = 0;
    forever #2 hclk = ~hclk;
  end
  task wrap_up;
    $display("mismatches %0d comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Wait for hready under a bound
  task wt;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_errors++;
      wrap_up;
    end
  endtask
  // One AHB single transfer, read data left in r
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wt;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    r = hrdata;
    // Idle cycle: the registered object read must see the new select or write
    @(posedge hclk);
  endtask
  // One bus bit; can_rx settles through the synchroniser first
  task sb(input logic b, input can_field_e f, input logic s, input logic [2:0] e);
    nb <= (tx_on | b) & ~brk;
    txl <= tx_on ? b : 1'b1;
    fld <= f;
    stf <= s;
    ei <= e;
    repeat (3) @(posedge hclk);
    bit_valid <= 1'b1;
    @(posedge hclk);
    bit_valid <= 1'b0;
  endtask
  // Stuffed bit with CRC over the de-stuffed stream
  task sd(input logic b, input can_field_e f);
    logic c;
    c = (b & ~brk) ^ crc[14];
    if (f != fld_crc) crc = {crc[13:0], 1'b0} ^ (c ? 15'h4599 : 15'h0);
    sb(b, f, 1'b0, 3'h0);
    run = (b == last) ? run + 1 : 1;
    last = b;
    if (run == 5 && !nostuff) begin
      sb(~b, f, 1'b1, 3'h0);
      last = ~b;
      run = 1;
    end
  endtask
  // Cases: 0 tx ok, 1 rx ok, 2 crc, 3 bit error, 4 lost arbitration, 5 stuff
  task frame(input logic tx, input int t, input logic [14:0] en);
    logic [3:0] a;
    logic [7:0] d;
    a = $random(seed);
    d = (t == 3) ? 8'h55 : $random(seed);
    a[3] = a[3] | (t == 4);
    if (t == 5) {a, d} = 12'h0;
    crc = 15'h0;
    run = 0;
    last = 1'b1;
    nostuff = (t == 5);
    tx_on <= tx;
    ten <= tx ? en : 15'h0;
    rm <= tx ? 15'h0 : en;
    @(posedge hclk);
    sd(1'b0, fld_sof);
    for (int i = 3; i >= 0; i--) begin
      brk = (t == 4 && i == 3);
      sd(a[i], fld_arb);
      if (brk) begin
        tx_on <= 1'b0;
        @(posedge hclk);
      end
    end
    for (int i = 7; i >= 0; i--) begin
      brk = (t == 3 && i == 2);
      sd(d[i], fld_ctrl_data);
    end
    brk = 1'b0;
    if (!tx) begin
      rx_dlc <= dlc;
      rx_dlc_valid <= 1'b1;
      @(posedge hclk);
      rx_dlc_valid <= 1'b0;
    end
    for (int i = 14; i >= 0; i--) begin
      sd(crc[i] ^ (t == 2 && i == 0), fld_crc);
    end
    // Dominant ack while flagged as error frame must not count as a bit error
    ef <= (t == 0);
    brk = (t == 0);
    sb(1'b1, fld_ack, 1'b0, 3'h0);
    ef <= 1'b0;
    brk = 1'b0;
    for (int i = 0; i < 8; i++) begin
      sb(1'b1, (i < 7) ? fld_eof : fld_idle, 1'b0, i[2:0]);
    end
    tx_on <= 1'b0;
    {ten, rm} <= 30'h0;
  endtask
  task run_case(input int t);
    logic [14:0] en;
    logic [7:0] e;
    int o;
    en = $random(seed);
    en[14] = 1'b1;
    o = 14;
    for (int i = 14; i >= 0; i--) begin
      if (en[i]) o = i;
    end
    dlc = (t == 1) ? $random(seed) : 4'h8;
    e = tbl[t] | ((dlc != 4'h8) ? 8'h80 : 8'h00);
    frame(t == 0 || t == 3 || t == 4, t, en);
    if (o < 14) begin
      ahb(1'b1, `OFS_OBJ_SEL, 32'he);
      ahb(1'b0, `OFS_STATUS, 32'h0);
      chk(r, 32'h0);
    end
    ahb(1'b1, `OFS_OBJ_SEL, o);
    ahb(1'b0, `OFS_STATUS, 32'h0);
    chk(r, {24'h0, e});
    ahb(1'b1, `OFS_STATUS, r & 32'h3);
    ahb(1'b0, `OFS_CTRL_LEN, 32'h0);
    chk(r, {28'h0, dlc});
    ahb(1'b0, `OFS_ACTIVE, 32'h0);
    chk(r, o);
    ahb(1'b1, `OFS_CTRL_LEN, 32'h8);
    ahb(1'b0, `OFS_INT_STATUS, 32'h0);
    chk(r, {27'h0, e[6:2]});
    chk(irq, 1'b0);
    ahb(1'b1, `OFS_INT_ENABLE, 32'h1f);
    ahb(1'b0, `OFS_INT_STATUS, 32'h0);
    chk(irq, |e[6:2]);
    ahb(1'b1, `OFS_INT_CLEAR, 32'h1f);
    ahb(1'b1, `OFS_INT_ENABLE, 32'h0);
    ahb(1'b0, `OFS_INT_STATUS, 32'h0);
    chk({r[4:0], irq}, 6'h0);
    $display("case %0d object %0d done", t, o);
  endtask
  initial begin
    seed = 93;
    {n_errors, cmp_count, brk} = 0;
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, bit_valid, stf, ei, ef} = 0;
    {txl, nb, tx_on, ten, rm, rx_dlc, rx_dlc_valid} = 38'h3000000000;
    fld = fld_idle;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({hreadyout, hresp, irq}, 3'h4);
    ahb(1'b0, `OFS_STATUS, 32'h0);
    chk(r, {24'h0, 8'hxx});
    ahb(1'b0, `OFS_INT_ENABLE, 32'h0);
    chk(r, 32'h0);
    ahb(1'b0, 8'h1c, 32'h0);
    chk(r, 32'h0);
    for (int i = 0; i < 15; i++) begin
      ahb(1'b1, `OFS_OBJ_SEL, i);
      ahb(1'b1, `OFS_STATUS, 32'h0);
      ahb(1'b1, `OFS_CTRL_LEN, 32'h8);
    end
    repeat (2) for (int t = 0; t < 6; t++) run_case(t);
    wrap_up;
  end
  initial begin
    repeat (100000) @(posedge hclk);
    n_errors++;
    wrap_up;
  end
endmodule // can_msg_object_status_flags_tb
`default_nettype wire
